// ===== spx_special.sv
`timescale 1ns/1ps
module spx_special #(
  parameter int DW = spx_pkg::DATA_W,
  parameter int HALF = spx_pkg::HALF_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic system_enable_in,
  input wire logic select_output_enable_in,
  input wire logic fault_detect_enable_in,
  input wire logic single_wire_select_in,
  input wire logic wait_stop_select_in,
  input wire logic wait_mode_in,
  input wire logic stop_mode_in,
  input wire logic ctrl_one_write_in,
  input wire logic master_select_in,
  input wire logic ctrl_two_write_in,
  input wire logic bidir_output_enable_in,
  input wire logic status_read_in,
  input wire logic data_read_in,
  input wire logic data_write_in,
  input wire logic [DW-1:0] data_wr_in,
  output logic [DW-1:0] data_rd_out,
  output logic master_select_out,
  output logic bidir_output_enable_out,
  output logic mode_fault_flag_out,
  output logic transfer_done_flag_out,
  output logic transmit_empty_flag_out,
  output logic irq_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic ss_in,
  output logic ss_out,
  output logic ss_oe_out
);
  localparam int CW = $clog2(HALF + 1);
  localparam int KW = $clog2(2 * DW + 1);

  typedef struct packed {
    spx_pkg::spx_state_t st;
    logic [CW-1:0] div;
    logic [KW-1:0] half;
    logic [DW-1:0] sh;
    logic [DW-1:0] rx;
    logic sck;
    logic master_select;
    logic bidir;
    logic mf;
    logic td;
    logic te;
    logic mf_arm;
    logic td_arm;
    logic te_arm;
    logic tx_pend;
    logic [DW-1:0] tx_buf;
    logic [DW-1:0] data;
    logic [DW-1:0] last_rx;
    logic [DW-1:0] tx_word;
    logic pend_v;
    logic [DW-1:0] pend;
    logic ss_s1;
    logic ss_s2;
    logic din_s1;
    logic din_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
  } spx_core_t;

  spx_core_t q_reg;
  spx_core_t q_next;
  logic sleep;
  logic m_act;
  logic auto_ss;
  logic fault;
  logic rx_evt;
  logic tick;
  logic [KW-1:0] half_inc;
  logic mst_on;
  logic slv_on;
  logic frame_rst;

  spx_link_if #(.DW(DW)) lk ();

  spx_slave_link #(.DW(DW)) u_link (
    .sck_in(sck_in),
    .rst_in(rst_in),
    .frame_rst_in(frame_rst),
    .mosi_in(mosi_in),
    .miso_in(miso_in),
    .lk(lk)
  );

  always_comb begin
    sleep = stop_mode_in | (wait_mode_in & wait_stop_select_in);
    m_act = q_reg.master_select & system_enable_in;
    auto_ss = m_act & select_output_enable_in & fault_detect_enable_in;
    // Auto SS owns the pin, so it cannot also watch it
    fault = m_act & fault_detect_enable_in & ~select_output_enable_in & ~q_reg.ss_s2;
    rx_evt = q_reg.tog_s2 != q_reg.tog_s3;
    tick = q_reg.div == CW'(HALF - 1);
    half_inc = q_reg.half + KW'(1);
    mst_on = m_act & ~q_reg.mf;
    slv_on = ~q_reg.master_select & system_enable_in & ~q_reg.mf;
  end

  always_comb begin
    q_next = q_reg;
    q_next.ss_s1 = ss_in;
    q_next.ss_s2 = q_reg.ss_s1;
    q_next.din_s1 = single_wire_select_in ? mosi_in : miso_in;
    q_next.din_s2 = q_reg.din_s1;
    q_next.tog_s1 = lk.rx_tog;
    q_next.tog_s2 = q_reg.tog_s1;
    q_next.tog_s3 = q_reg.tog_s2;

    if (ctrl_two_write_in) begin
      q_next.bidir = bidir_output_enable_in;
    end
    if (ctrl_one_write_in) begin
      q_next.master_select = master_select_in;
    end
    if (status_read_in && q_reg.mf) begin
      q_next.mf_arm = 1'b1;
    end
    if (status_read_in && q_reg.td) begin
      q_next.td_arm = 1'b1;
    end
    if (status_read_in && q_reg.te) begin
      q_next.te_arm = 1'b1;
    end
    if (ctrl_one_write_in && q_reg.mf_arm) begin
      q_next.mf = 1'b0;
      q_next.mf_arm = 1'b0;
    end
    if (data_read_in && q_reg.td_arm) begin
      q_next.td = 1'b0;
      q_next.td_arm = 1'b0;
    end
    if (data_write_in) begin
      q_next.tx_buf = data_wr_in;
      q_next.tx_pend = 1'b1;
      if (q_reg.te_arm) begin
        q_next.te = 1'b0;
        q_next.te_arm = 1'b0;
      end
    end
    // Slave word only changes between frames, never under a running SCK
    if (q_reg.ss_s2) begin
      q_next.tx_word = q_reg.tx_pend ? q_reg.tx_buf : q_reg.last_rx;
    end

    unique case (q_reg.st)
      spx_pkg::SPX_IDLE: begin
        if (m_act && q_reg.tx_pend && !sleep) begin
          q_next.st = spx_pkg::SPX_SHIFT;
          q_next.sh = q_reg.tx_buf;
          q_next.tx_pend = 1'b0;
          q_next.te = 1'b1;
          q_next.half = '0;
          q_next.div = '0;
        end
      end
      spx_pkg::SPX_SHIFT: begin
        if (!sleep) begin
          q_next.div = q_reg.div + CW'(1);
          if (tick) begin
            q_next.div = '0;
            q_next.half = half_inc;
            q_next.sck = half_inc[0];
            if (half_inc[0]) begin
              q_next.rx = {q_reg.rx[DW-2:0], q_reg.din_s2};
            end else begin
              q_next.sh = {q_reg.sh[DW-2:0], 1'b0};
            end
            if (half_inc == KW'(2 * DW)) begin
              q_next.st = spx_pkg::SPX_TAIL;
            end
          end
        end
      end
      spx_pkg::SPX_TAIL: begin
        if (!sleep) begin
          q_next.div = q_reg.div + CW'(1);
          if (tick) begin
            q_next.div = '0;
            q_next.st = spx_pkg::SPX_IDLE;
            q_next.data = q_reg.rx;
            q_next.last_rx = q_reg.rx;
            q_next.td = 1'b1;
          end
        end
      end
    endcase

    if (rx_evt && slv_on) begin
      if (sleep) begin
        q_next.pend_v = 1'b1;
        q_next.pend = lk.rx_word;
      end else begin
        q_next.data = lk.rx_word;
        q_next.last_rx = lk.rx_word;
        q_next.td = 1'b1;
        if (q_reg.tx_pend) begin
          q_next.tx_pend = 1'b0;
          q_next.te = 1'b1;
        end
      end
    end else if (q_reg.pend_v && !sleep) begin
      q_next.pend_v = 1'b0;
      q_next.data = q_reg.pend;
      q_next.last_rx = q_reg.pend;
      q_next.td = 1'b1;
    end

    if (!system_enable_in) begin
      q_next.st = spx_pkg::SPX_IDLE;
      q_next.sck = 1'b0;
    end

    // Fault is applied last so its set beats any clear in the same cycle
    if (fault) begin
      q_next.mf = 1'b1;
      q_next.master_select = 1'b0;
      if (single_wire_select_in) begin
        q_next.bidir = 1'b0;
      end
      q_next.st = spx_pkg::SPX_IDLE;
      q_next.sck = 1'b0;
      q_next.pend_v = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_reg <= '0;
      q_reg.st <= spx_pkg::SPX_IDLE;
      q_reg.master_select <= spx_pkg::MASTER_RST;
      q_reg.bidir <= spx_pkg::BIDIR_OE_RST;
      q_reg.te <= spx_pkg::TX_EMPTY_RST;
      q_reg.data <= spx_pkg::DATA_RST;
      q_reg.ss_s1 <= spx_pkg::SS_IDLE_LEVEL;
      q_reg.ss_s2 <= spx_pkg::SS_IDLE_LEVEL;
    end else begin
      q_reg <= q_next;
    end
  end

  // Link frame ends with SS itself, since SCK may stop with it
  assign frame_rst = rst_in | ss_in | ~slv_on;
  assign lk.tx_word = q_reg.tx_word;
  assign lk.single_wire = single_wire_select_in;

  assign data_rd_out = q_reg.data;
  assign master_select_out = q_reg.master_select;
  assign bidir_output_enable_out = q_reg.bidir;
  assign mode_fault_flag_out = q_reg.mf;
  assign transfer_done_flag_out = q_reg.td;
  assign transmit_empty_flag_out = q_reg.te;
  assign irq_out = system_enable_in & (q_reg.mf | q_reg.td | q_reg.te);

  assign sck_out = q_reg.sck;
  assign sck_oe_out = mst_on;
  assign mosi_out = q_reg.sh[DW-1];
  assign mosi_oe_out = mst_on & (~single_wire_select_in | q_reg.bidir);
  assign miso_out = lk.tx_bit;
  assign miso_oe_out = slv_on & ~q_reg.ss_s2 & (~single_wire_select_in | q_reg.bidir);
  assign ss_out = q_reg.st == spx_pkg::SPX_IDLE;
  assign ss_oe_out = auto_ss;

  sequence s_last_edge;
    q_reg.st == spx_pkg::SPX_SHIFT && tick && !sleep && !fault && system_enable_in
      && q_reg.half == KW'(2 * DW - 1);
  endsequence

  sequence s_tail_end;
    q_reg.st == spx_pkg::SPX_TAIL && tick && !sleep && !fault && system_enable_in;
  endsequence

  property p_auto_ss_low;
    @(posedge ref_clk_in) disable iff (rst_in)
    auto_ss && q_reg.st != spx_pkg::SPX_IDLE |-> ss_oe_out && !ss_out;
  endproperty
  a_auto_ss_low: assert property (p_auto_ss_low) else $error("auto select not low in transfer");

  property p_auto_ss_only;
    @(posedge ref_clk_in) disable iff (rst_in)
    ss_oe_out |-> master_select_out && select_output_enable_in && fault_detect_enable_in;
  endproperty
  a_auto_ss_only: assert property (p_auto_ss_only) else $error("select driven outside master");

  property p_fault_cause;
    @(posedge ref_clk_in) disable iff (rst_in)
    $rose(mode_fault_flag_out) |-> $past(master_select_out && fault_detect_enable_in && !select_output_enable_in);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("mode fault without cause");

  property p_fault_sets;
    @(posedge ref_clk_in) disable iff (rst_in)
    fault |=> mode_fault_flag_out && !master_select_out && q_reg.st == spx_pkg::SPX_IDLE;
  endproperty
  a_fault_sets: assert property (p_fault_sets) else $error("fault did not take effect");

  property p_fault_quiet;
    @(posedge ref_clk_in) disable iff (rst_in)
    mode_fault_flag_out |-> !sck_oe_out && !mosi_oe_out && !miso_oe_out;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("pin driven during mode fault");

  property p_bidir_clear;
    @(posedge ref_clk_in) disable iff (rst_in)
    fault && single_wire_select_in |=> !bidir_output_enable_out && !mosi_oe_out;
  endproperty
  a_bidir_clear: assert property (p_bidir_clear) else $error("output enable kept after fault");

  property p_fault_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    mode_fault_flag_out && !(ctrl_one_write_in && q_reg.mf_arm) |=> mode_fault_flag_out;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("mode fault cleared early");

  property p_freeze;
    @(posedge ref_clk_in) disable iff (rst_in)
    sleep && !fault && system_enable_in && q_reg.st == spx_pkg::SPX_SHIFT
      |=> $stable(q_reg.half) && $stable(sck_out) && $stable(q_reg.sh);
  endproperty
  a_freeze: assert property (p_freeze) else $error("master moved while frozen");

  property p_sleep_no_flag;
    @(posedge ref_clk_in) disable iff (rst_in)
    sleep && !master_select_out |=> !$rose(transfer_done_flag_out);
  endproperty
  a_sleep_no_flag: assert property (p_sleep_no_flag) else $error("slave flagged in low power");

  property p_irq;
    @(posedge ref_clk_in) disable iff (rst_in)
    (system_enable_in && (transfer_done_flag_out || transmit_empty_flag_out || mode_fault_flag_out))
      ##1 !system_enable_in |-> irq_out != $past(irq_out) || !irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("request while disabled");

  property p_done_tail;
    @(posedge ref_clk_in) disable iff (rst_in)
    s_last_edge |=> q_reg.st == spx_pkg::SPX_TAIL && !sck_out && q_reg.div == '0;
  endproperty
  a_done_tail: assert property (p_done_tail) else $error("no trailing half after last edge");

  property p_tail_flag;
    @(posedge ref_clk_in) disable iff (rst_in)
    s_tail_end |=> transfer_done_flag_out && data_rd_out == $past(q_reg.rx);
  endproperty
  a_tail_flag: assert property (p_tail_flag) else $error("done flag or copy missing");
endmodule

// ===== spx_pkg.sv
package spx_pkg;
  localparam int DATA_W = 8;
  // Module clock cycles per SCK half period
  localparam int HALF_CYC = 4;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic TX_EMPTY_RST = 1'b1;
  localparam logic MASTER_RST = 1'b0;
  localparam logic BIDIR_OE_RST = 1'b0;
  localparam logic SS_IDLE_LEVEL = 1'b1;

  typedef enum logic [2:0] {
    SPX_IDLE = 3'b001,
    SPX_SHIFT = 3'b010,
    SPX_TAIL = 3'b100
  } spx_state_t;
endpackage

// ===== spx_link_if.sv
`timescale 1ns/1ps
interface spx_link_if #(parameter int DW = spx_pkg::DATA_W);
  logic [DW-1:0] tx_word;
  logic single_wire;
  logic [DW-1:0] rx_word;
  logic rx_tog;
  logic tx_bit;

  modport sys (output tx_word, output single_wire, input rx_word, input rx_tog, input tx_bit);
  modport lnk (input tx_word, input single_wire, output rx_word, output rx_tog, output tx_bit);
endinterface

// ===== spx_slave_link.sv
`timescale 1ns/1ps
module spx_slave_link #(
  parameter int DW = spx_pkg::DATA_W
) (
  input wire logic sck_in,
  input wire logic rst_in,
  input wire logic frame_rst_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  spx_link_if.lnk lk
);
  localparam int BW = $clog2(DW);

  typedef struct packed {
    logic [DW-1:0] sh;
    logic [DW-1:0] rx;
    logic [BW-1:0] cnt;
  } spx_frame_t;

  typedef struct packed {
    logic [DW-1:0] word;
    logic tog;
  } spx_hand_t;

  spx_frame_t f_reg;
  spx_frame_t f_next;
  spx_hand_t h_reg;
  spx_hand_t h_next;
  logic din;
  logic [DW-1:0] src;

  always_comb begin
    f_next = f_reg;
    h_next = h_reg;
    // Single-wire slave listens on its one data pin
    din = lk.single_wire ? miso_in : mosi_in;
    // Word is frozen by the core while SS is low
    src = (f_reg.cnt == '0) ? lk.tx_word : f_reg.sh;
    f_next.sh = {src[DW-2:0], 1'b0};
    f_next.rx = {f_reg.rx[DW-2:0], din};
    if (f_reg.cnt == BW'(DW - 1)) begin
      f_next.cnt = '0;
      h_next.word = {f_reg.rx[DW-2:0], din};
      h_next.tog = ~h_reg.tog;
    end else begin
      f_next.cnt = f_reg.cnt + BW'(1);
    end
  end

  // Frame state restarts with SS; the handoff must survive between frames
  always_ff @(posedge sck_in or posedge frame_rst_in) begin
    if (frame_rst_in) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  always_ff @(posedge sck_in or posedge rst_in) begin
    if (rst_in) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  // Shifting keeps going on SCK alone, so low-power modes never desync it
  assign lk.tx_bit = (f_reg.cnt == '0) ? lk.tx_word[DW-1] : f_reg.sh[DW-1];
  assign lk.rx_word = h_reg.word;
  assign lk.rx_tog = h_reg.tog;
endmodule

// ===== spx_far_model.sv
`timescale 1ns/1ps
module spx_far_model (
  input wire logic sck_in,
  input wire logic ss_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  input wire logic [7:0] reply_in,
  output logic sck_out,
  output logic ss_out,
  output logic mosi_out,
  output logic miso_out
);
  logic [7:0] sh;
  logic [7:0] rx_byte;
  initial begin
    sck_out = 1'b0;
    ss_out = 1'b1;
    mosi_out = 1'b0;
    miso_out = 1'b0;
    rx_byte = 8'h00;
  end
  // Slave role: bit 7 out as soon as selected
  always @(negedge ss_in) begin
    sh = reply_in;
    miso_out = sh[7];
  end
  always @(posedge sck_in) if (!ss_in) rx_byte = {rx_byte[6:0], mosi_in};
  always @(negedge sck_in) if (!ss_in) begin
    sh = sh << 1;
    miso_out = sh[7];
  end
  // Released line must not keep a valid-looking level
  always @(posedge ss_in) miso_out = ~miso_out;
  task automatic hold_ss(input logic v);
    ss_out = v;
  endtask
  // Master role, 15 ns link clock only inside the frame; long lead lets the select sync settle
  task automatic xfer(input logic [7:0] b, output logic [7:0] got);
    ss_out = 1'b0;
    #400;
    for (int i = 7; i >= 0; i--) begin
      mosi_out = b[i];
      #7.5;
      got[i] = miso_in;
      sck_out = 1'b1;
      #7.5;
      sck_out = 1'b0;
    end
    #400;
    mosi_out = ~mosi_out;
    ss_out = 1'b1;
  endtask
endmodule

// ===== spx_special_tb.sv
`timescale 1ns/1ps
module spx_special_tb;
  logic ref_clk_in, rst_in, sysen, selo, fden, swsel, wss, wmode, smode, msel, bidir, td_q;
  logic [4:0] stb;
  logic [7:0] wdata, got, b, m, reply, s, rd;
  logic ms, bo, mf, td, te, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  wire logic p_sck, p_ss, p_mosi, p_miso;
  wire logic sck_w = sck_oe ? sck_o : p_sck;
  wire logic ss_w = ss_oe ? ss_o : p_ss;
  wire logic mosi_w = mosi_oe ? mosi_o : p_mosi;
  wire logic miso_w = miso_oe ? miso_o : p_miso;
  int n_errors = 0;
  int num_checks = 0;
  logic [7:0] exp_q[$];

  spx_special DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .system_enable_in(sysen),
    .select_output_enable_in(selo), .fault_detect_enable_in(fden), .single_wire_select_in(swsel),
    .wait_stop_select_in(wss), .wait_mode_in(wmode), .stop_mode_in(smode), .ctrl_one_write_in(stb[3]),
    .master_select_in(msel), .ctrl_two_write_in(stb[4]), .bidir_output_enable_in(bidir),
    .status_read_in(stb[0]), .data_read_in(stb[1]), .data_write_in(stb[2]), .data_wr_in(wdata),
    .data_rd_out(rd), .master_select_out(ms), .bidir_output_enable_out(bo), .mode_fault_flag_out(mf),
    .transfer_done_flag_out(td), .transmit_empty_flag_out(te), .irq_out(irq), .sck_in(sck_w),
    .sck_out(sck_o), .sck_oe_out(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_o), .miso_oe_out(miso_oe), .ss_in(ss_w), .ss_out(ss_o),
    .ss_oe_out(ss_oe));
  spx_far_model far (.sck_in(sck_w), .ss_in(ss_w), .mosi_in(mosi_w), .miso_in(miso_w), .reply_in(reply),
    .sck_out(p_sck), .ss_out(p_ss), .mosi_out(p_mosi), .miso_out(p_miso));

  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic pulse(input logic [4:0] k);
    @(posedge ref_clk_in) stb <= k;
    @(posedge ref_clk_in) stb <= 5'h00;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (td !== 1'b1 && n < 400) begin
      @(negedge ref_clk_in);
      n++;
    end
    check("done_wait", {7'h00, td}, 8'h01);
  endtask

  // Monitor: each new received byte is matched against the oldest note
  always @(negedge ref_clk_in) begin
    td_q <= td;
    if (td === 1'b1 && td_q === 1'b0) begin
      if (exp_q.size() == 0) check("rx_unexpected", 8'h01, 8'h00);
      else check("data_rd", rd, exp_q.pop_front());
    end
  end

  initial begin
    #1_000_000;
    n_errors++;
    $display("FAIL watchdog expected finish seen hang");
    wrap_up;
  end

  initial begin
    {sysen, selo, fden, swsel, wss, wmode, smode, msel, bidir, td_q} = '0;
    stb = 5'h00;
    wdata = 8'h00;
    reply = 8'h00;
    rst_in = 1'b1;
    void'($urandom(32'h7035));
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(negedge ref_clk_in);
    check("data_rd_rst", rd, 8'h00);
    check("irq_off", {7'h00, irq}, 8'h00);
    @(posedge ref_clk_in) {sysen, selo, fden, msel} <= 4'hf;
    pulse(5'h08);
    @(negedge ref_clk_in);
    check("irq_on", {7'h00, irq}, 8'h01);
    check("ss_oe", {7'h00, ss_oe}, 8'h01);
    $display("test reset_irq done");
    for (int t = 0; t < 2; t++) begin
      b = $urandom;
      reply = $urandom;
      exp_q.push_back(reply);
      @(posedge ref_clk_in) wdata <= b;
      pulse(5'h04);
      repeat (2) @(negedge ref_clk_in);
      check("ss_busy", {7'h00, ss_o}, 8'h00);
      check("sck_oe", {7'h00, sck_oe}, 8'h01);
      if (t == 1) begin
        repeat (10) @(posedge ref_clk_in);
        {wss, wmode} <= 2'b11;
        repeat (2) @(negedge ref_clk_in);
        s = {7'h00, sck_o};
        repeat (12) @(negedge ref_clk_in);
        check("sck_frozen", {7'h00, sck_o}, s);
        check("done_frozen", {7'h00, td}, 8'h00);
        @(posedge ref_clk_in) {wmode, smode} <= 2'b01;
        repeat (2) @(negedge ref_clk_in);
        s = {7'h00, sck_o};
        repeat (12) @(negedge ref_clk_in);
        check("sck_stop", {7'h00, sck_o}, s);
        @(posedge ref_clk_in) smode <= 1'b0;
      end
      wait_done;
      check("ss_idle", {7'h00, ss_o}, 8'h01);
      check("mosi_seen", far.rx_byte, b);
      pulse(5'h02);
      @(negedge ref_clk_in);
      check("done_no_arm", {7'h00, td}, 8'h01);
      pulse(5'h01);
      pulse(5'h02);
      @(negedge ref_clk_in);
      check("done_clr", {7'h00, td}, 8'h00);
      $display("test master_xfer %0d done", t);
    end
    @(posedge ref_clk_in) {selo, fden, swsel, bidir} <= 4'h3;
    pulse(5'h10);
    @(negedge ref_clk_in);
    check("bidir_on", {6'h00, bo, mosi_oe}, 8'h03);
    far.hold_ss(1'b0);
    repeat (6) @(negedge ref_clk_in);
    check("no_fault", {7'h00, mf}, 8'h00);
    @(posedge ref_clk_in) fden <= 1'b1;
    repeat (4) @(negedge ref_clk_in);
    check("fault", {7'h00, mf}, 8'h01);
    check("fault_master", {7'h00, ms}, 8'h00);
    check("fault_bidir", {7'h00, bo}, 8'h00);
    check("fault_pins", {5'h00, sck_oe, mosi_oe, miso_oe}, 8'h00);
    @(posedge ref_clk_in) {msel, swsel} <= 2'b00;
    pulse(5'h08);
    @(negedge ref_clk_in);
    check("fault_no_arm", {7'h00, mf}, 8'h01);
    far.hold_ss(1'b1);
    pulse(5'h01);
    pulse(5'h08);
    @(negedge ref_clk_in);
    check("fault_clr", {7'h00, mf}, 8'h00);
    $display("test mode_fault done");
    b = $urandom;
    m = $urandom;
    exp_q.push_back(m);
    @(posedge ref_clk_in) wdata <= b;
    pulse(5'h04);
    repeat (2) @(negedge ref_clk_in);
    far.xfer(m, got);
    wait_done;
    check("slave_tx", got, b);
    check("empty_set", {7'h00, te}, 8'h01);
    $display("test slave_xfer done");
    wrap_up;
  end
endmodule
